// ### mpc_pin_route.sv
// multipurpose pin config, power-good status and buck1 routing slave
// Functional notes
// - output style bit picks push-pull or open-drain
// - direction bit: clear hi-z input, set output
// - resistor bit attaches resistor only as input
// - polarity bit: clear pulldown, set pullup
// - status bit 5 shows usb-ok interrupt active
// - status bits 2..0 show buck3..buck1 interrupts
// - route bit 7 flags buck1 power-good change
// - route bits 6..3 send buck1 to pins
// - output value bit: clear ground, set high/release
`timescale 1ns/1ns
`include "mpc_route_regs.svh"
module mpc_pin_route
  import mpc_route_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe_n,
  output logic pullUpEn,
  output logic pullDownEn,
  input wire logic usbOkIrqIn,
  input wire logic [2:0] buckPgIrqIn,
  input wire logic buck1PgIn,
  input wire logic [3:0] otherRouteIrq,
  output logic [3:0] routedPin,
  output logic irq
);

  // ==========================================================
  // elaboration check
  generate
    if (ADDR_W < 10) begin : g_bad_width
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  // ==========================================================
  // declarations
  logic [4:0] pinCfg_ff;
  logic [3:0] routeSel_ff;
  logic changeFlag_ff;
  logic [3:0] srcSeen_ff;
  logic buck1Pg_ff;
  logic [`EVT_W-1:0] evtSts_ff;
  logic [`EVT_W-1:0] evtMask_ff;
  logic awFull_ff;
  logic wFull_ff;
  logic [7:0] awIdx_ff;
  logic [7:0] wByte_ff;
  logic wLane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic awready_ff;
  logic wready_ff;
  rd_state_e rdState_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [3:0] routed_ff;
  logic irq_ff;
  logic nxt_awFull;
  logic nxt_wFull;
  logic doWrite;
  logic doRead;
  logic [7:0] rdIdx;
  logic [`EVT_W-1:0] evtSet;
  logic [`EVT_W-1:0] evtClr;
  logic [3:0] srcNow;
  logic b1Change;
  logic clrChange;

  pin_cfg_if cfgBus ();

  // register index from a byte address
  function automatic logic [7:0] regIdx(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // true when the index names a register of this block
  function automatic logic isMapped(input logic [7:0] idx);
    return idx == `IDX_PIN_SEVEN_CONFIG || idx == `IDX_PIN_IRQ_STATUS ||
      idx == `IDX_BUCK1_ROUTE || idx == `IDX_EVT_STATUS ||
      idx == `IDX_EVT_MASK;
  endfunction

  // ==========================================================
  // write address and data, taken in either order
  assign doWrite = awFull_ff && wFull_ff && !bvalid_ff;
  assign nxt_awFull = awFull_ff ? !doWrite : (awvalid && awready_ff);
  assign nxt_wFull = wFull_ff ? !doWrite : (wvalid && wready_ff);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awFull_ff <= 1'b0;
      wFull_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end else begin
      awFull_ff <= nxt_awFull;
      wFull_ff <= nxt_wFull;
      awready_ff <= !nxt_awFull;
      wready_ff <= !nxt_wFull;
    end
  end

  // payload capture at each handshake
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awIdx_ff <= 8'h00;
      wByte_ff <= 8'h00;
      wLane_ff <= 1'b0;
    end else begin
      if (awvalid && awready_ff) begin
        awIdx_ff <= regIdx(awaddr);
      end
      if (wvalid && wready_ff) begin
        wByte_ff <= wdata[7:0];
        wLane_ff <= wstrb[0];
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= isMapped(awIdx_ff) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // software-written configuration; only byte lane 0 carries data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinCfg_ff <= `PIN_CFG_RST;
      routeSel_ff <= `ROUTE_RST;
      evtMask_ff <= `EVT_RST;
    end else if (doWrite && wLane_ff) begin
      if (awIdx_ff == `IDX_PIN_SEVEN_CONFIG) begin
        pinCfg_ff <= wByte_ff[4:0];
      end
      if (awIdx_ff == `IDX_BUCK1_ROUTE) begin
        routeSel_ff <= wByte_ff[`ROUTE_SEL_MSB:`ROUTE_SEL_LSB];
      end
      if (awIdx_ff == `IDX_EVT_MASK) begin
        evtMask_ff <= wByte_ff[`EVT_W-1:0];
      end
    end
  end

  // config to the pad
  assign cfgBus.outValue = pinCfg_ff[`PIN_OUT_VALUE_BIT];
  assign cfgBus.openDrain = pinCfg_ff[`PIN_OPEN_DRAIN_BIT];
  assign cfgBus.dirOut = pinCfg_ff[`PIN_DIR_OUT_BIT];
  assign cfgBus.resPresent = pinCfg_ff[`PIN_RES_PRESENT_BIT];
  assign cfgBus.pullupSel = pinCfg_ff[`PIN_PULLUP_BIT];

  mpc_pin_pad u_pad (
    .mclk(mclk),
    .rst_n(rst_n),
    .cfg(cfgBus.pad),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe_n(pinOe_n),
    .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn)
  );

  // ==========================================================
  // live interrupt sources: {usb, buck3, buck2, buck1}
  assign srcNow = {usbOkIrqIn, buckPgIrqIn};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srcSeen_ff <= 4'h0;
      buck1Pg_ff <= 1'b0;
    end else begin
      srcSeen_ff <= srcNow;
      buck1Pg_ff <= buck1PgIn;
    end
  end

  // change flag clears when software reads the route register
  assign b1Change = buck1PgIn != buck1Pg_ff;
  assign clrChange = doRead && rdIdx == `IDX_BUCK1_ROUTE;

  // set wins over clear, so a change during the read is kept
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      changeFlag_ff <= 1'b0;
    end else if (b1Change) begin
      changeFlag_ff <= 1'b1;
    end else if (clrChange) begin
      changeFlag_ff <= 1'b0;
    end
  end

  // ==========================================================
  // routed pins: its other source, or buck1 when selected for it, asserts each pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_route
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          routed_ff[gi] <= 1'b0;
        end else begin
          routed_ff[gi] <= (buckPgIrqIn[0] && routeSel_ff[gi]) ||
            otherRouteIrq[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // sticky events, write one to clear, set wins
  assign evtSet = {srcNow[2:0] & ~srcSeen_ff[2:0],
    usbOkIrqIn && !srcSeen_ff[3], b1Change};
  assign evtClr = (doWrite && wLane_ff && awIdx_ff == `IDX_EVT_STATUS) ?
    wByte_ff[`EVT_W-1:0] : `EVT_RST;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evtSts_ff <= `EVT_RST;
      irq_ff <= 1'b0;
    end else begin
      evtSts_ff <= (evtSts_ff & ~evtClr) | evtSet;
      irq_ff <= |(((evtSts_ff & ~evtClr) | evtSet) & evtMask_ff);
    end
  end

  // ==========================================================
  // read channel; one read at a time keeps rdata stable
  assign doRead = arvalid && rdState_ff[0];
  assign rdIdx = regIdx(araddr);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdState_ff <= RD_IDLE;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end else begin
      unique case (rdState_ff)
        RD_IDLE: begin
          if (arvalid) begin
            rdState_ff <= RD_DATA;
            rresp_ff <= isMapped(rdIdx) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (rdIdx)
              `IDX_PIN_SEVEN_CONFIG: rdata_ff <= {24'h000000,
                cfgBus.pinState, 2'b00, pinCfg_ff};
              `IDX_PIN_IRQ_STATUS: rdata_ff <= {26'h0,
                srcSeen_ff[3], 2'b00, srcSeen_ff[2:0]};
              `IDX_BUCK1_ROUTE: rdata_ff <= {24'h000000,
                changeFlag_ff, routeSel_ff, 3'b000};
              `IDX_EVT_STATUS: rdata_ff <= {27'h0, evtSts_ff};
              `IDX_EVT_MASK: rdata_ff <= {27'h0, evtMask_ff};
              default: rdata_ff <= 32'h0000_0000;
            endcase
          end
        end
        RD_DATA: begin
          if (rready) begin
            rdState_ff <= RD_IDLE;
          end
        end
        default: rdState_ff <= RD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = rdState_ff[0];
  assign rvalid = rdState_ff[1];
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign routedPin = routed_ff;
  assign irq = irq_ff;

  // ==========================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence rd_route_s;
    doRead && rdIdx == `IDX_BUCK1_ROUTE;
  endsequence
  sequence rd_status_s;
    doRead && rdIdx == `IDX_PIN_IRQ_STATUS;
  endsequence

  usb_status_a: assert property (rd_status_s |=>
    rdata[`STS_USB_OK_BIT] == $past(srcSeen_ff[3]))
    else $error("usb-ok status bit wrong");
  buck_status_a: assert property (rd_status_s |=>
    rdata[2:0] == $past(srcSeen_ff[2:0]) && rdata[7:6] == 2'b00)
    else $error("buck status bits wrong");
  change_set_a: assert property (b1Change |=> changeFlag_ff)
    else $error("change flag not set");
  change_read_a: assert property (rd_route_s ##0 !b1Change |=>
    !changeFlag_ff && rdata[`ROUTE_CHANGE_BIT] == $past(changeFlag_ff))
    else $error("change flag not cleared by read");
  route_pin_a: assert property (buckPgIrqIn[0] |=>
    (routedPin & $past(routeSel_ff)) == $past(routeSel_ff))
    else $error("selected routed pin not asserted");
  route_off_a: assert property (
    !buckPgIrqIn[0] && otherRouteIrq == 4'h0 |=> routedPin == 4'h0)
    else $error("routed pin asserted with no source");
  route_any_a: assert property (otherRouteIrq != 4'h0 |=>
    (routedPin & $past(otherRouteIrq)) == $past(otherRouteIrq))
    else $error("other routed source ignored");
  cfg_to_pad_a: assert property (doWrite && wLane_ff &&
    awIdx_ff == `IDX_PIN_SEVEN_CONFIG |=> ##1 pinOe_n ==
    (!pinCfg_ff[`PIN_DIR_OUT_BIT] || pinCfg_ff[`PIN_OPEN_DRAIN_BIT] &&
    pinCfg_ff[`PIN_OUT_VALUE_BIT]))
    else $error("pin enable does not follow config");
  irq_level_a: assert property (
    |(evtSts_ff & evtMask_ff) && evtClr == 5'h00 |=> irq)
    else $error("irq low with unmasked event");

endmodule

// ### mpc_route_regs.svh
// register indexes, field positions and reset values of the pin/route block
`ifndef MPC_ROUTE_REGS_SVH
`define MPC_ROUTE_REGS_SVH

// register indexes; byte address is four times the index
`define IDX_PIN_SEVEN_CONFIG 8'h6E
`define IDX_PIN_IRQ_STATUS 8'h6F
`define IDX_BUCK1_ROUTE 8'h70
`define IDX_EVT_STATUS 8'h80
`define IDX_EVT_MASK 8'h81

// pin_seven_config fields
`define PIN_STATE_BIT 7
`define PIN_OUT_VALUE_BIT 4
`define PIN_OPEN_DRAIN_BIT 3
`define PIN_DIR_OUT_BIT 2
`define PIN_RES_PRESENT_BIT 1
`define PIN_PULLUP_BIT 0
`define PIN_CFG_RST 5'h00

// pin_interrupt_status fields
`define STS_USB_OK_BIT 5
`define STS_BUCK3_BIT 2
`define STS_BUCK2_BIT 1
`define STS_BUCK1_BIT 0

// buck_one_interrupt_route fields
`define ROUTE_CHANGE_BIT 7
`define ROUTE_SEL_LSB 3
`define ROUTE_SEL_MSB 6
`define ROUTE_RST 4'h0

// event status / mask layout
`define EVT_B1_CHANGE_BIT 0
`define EVT_USB_OK_BIT 1
`define EVT_BUCK1_BIT 2
`define EVT_BUCK2_BIT 3
`define EVT_BUCK3_BIT 4
`define EVT_W 5
`define EVT_RST 5'h00

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### mpc_route_pkg.sv
// types shared by the pin/route block
package mpc_route_pkg;
  // read channel states, one-hot
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;
endpackage

// ### pin_cfg_if.sv
// configuration and observed level of the multipurpose pin
`timescale 1ns/1ns
interface pin_cfg_if;
  logic dirOut;
  logic openDrain;
  logic outValue;
  logic resPresent;
  logic pullupSel;
  logic pinState;
  modport ctrl (
    output dirOut, output openDrain, output outValue,
    output resPresent, output pullupSel, input pinState
  );
  modport pad (
    input dirOut, input openDrain, input outValue,
    input resPresent, input pullupSel, output pinState
  );
endinterface

// ### mpc_pin_pad.sv
// drive, enable and pull control of the multipurpose pin
`timescale 1ns/1ns
module mpc_pin_pad (
  input wire logic mclk,
  input wire logic rst_n,
  pin_cfg_if.pad cfg,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe_n,
  output logic pullUpEn,
  output logic pullDownEn
);

  logic state_ff;

  // ==========================================================
  // output drive
  // in output direction a low level always drives; a high level in open drain just releases
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b0;
      pinOe_n <= 1'b1;
    end else begin
      pinOut <= cfg.outValue;
      pinOe_n <= !cfg.dirOut || (cfg.openDrain && cfg.outValue);
    end
  end

  // ==========================================================
  // pull resistor, only in input direction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pullUpEn <= 1'b0;
      pullDownEn <= 1'b0;
    end else begin
      pullUpEn <= !cfg.dirOut && cfg.resPresent &&
        cfg.pullupSel;
      pullDownEn <= !cfg.dirOut && cfg.resPresent &&
        !cfg.pullupSel;
    end
  end

  // ==========================================================
  // pin level seen by software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= 1'b0;
    end else begin
      state_ff <= pinIn;
    end
  end
  assign cfg.pinState = state_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  input_hiz_a: assert property (!cfg.dirOut |=> pinOe_n)
    else $error("pin driven while input");
  od_release_a: assert property (
    cfg.dirOut && cfg.openDrain && cfg.outValue |=> pinOe_n)
    else $error("open drain high not released");
  pushpull_a: assert property (
    cfg.dirOut && !cfg.openDrain |=>
    !pinOe_n && pinOut == $past(cfg.outValue))
    else $error("push-pull drive wrong");
  pull_out_a: assert property (
    cfg.dirOut |=> !pullUpEn && !pullDownEn)
    else $error("pull active in output mode");
  pull_sel_a: assert property (
    !cfg.dirOut && cfg.resPresent |=>
    pullUpEn == $past(cfg.pullupSel) && pullDownEn == !$past(cfg.pullupSel))
    else $error("pull polarity wrong");

endmodule

// ### mpc_pin_partner.sv
// pin-side model: resolves the level seen on the multipurpose pin
`timescale 1ns/1ns
module mpc_pin_partner (
  input wire logic mclk,
  input wire logic pinOut,
  input wire logic pinOe_n,
  input wire logic pullUpEn,
  input wire logic pullDownEn,
  output logic pinIn
);
  logic wobble;
  // ==============================================
  // pin resolution
  // a floating pin must not settle to a tidy value, so it toggles
  always @(posedge mclk) begin
    wobble <= (wobble === 1'b1) ? 1'b0 : 1'b1;
  end
  // device drive wins, then the pulls, else the floating pattern
  always_comb begin
    if (pinOe_n === 1'b0) begin
      pinIn = pinOut;
    end else if (pullUpEn === 1'b1) begin
      pinIn = 1'b1;
    end else if (pullDownEn === 1'b1) begin
      pinIn = 1'b0;
    end else begin
      pinIn = wobble;
    end
  end
endmodule

// ### test_mpc_pin_config_pg_interrupt_route.sv
// self-checking bench for the pin config and power-good routing block
`timescale 1ns/1ns
`include "mpc_route_regs.svh"
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module test_mpc_pin_config_pg_interrupt_route;
  logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, otherRouteIrq, routedPin, pat;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic pinIn, pinOut, pinOe_n, pullUpEn, pullDownEn;
  logic usbOkIrqIn, buck1PgIn;
  logic [2:0] buckPgIrqIn;
  logic [7:0] cfg;
  logic drv;
  int failures = 0;
  int checksDone = 0;
  logic [7:0] cfgs [8] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h14, 8'h0C,
    8'h1C, 8'h07};

  mpc_pin_route DUT (.*);
  mpc_pin_partner pinSide (.*);

  // ==============================================
  // clock, bus tasks, closing
  always #50 mclk = ~mclk;

  // one write; master releases each channel once it is taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    if (n >= 40) failures++;
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read; data taken at the edge that sees rvalid
  task automatic rdr(input logic [7:0] idx);
    int n;
    @(posedge mclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    if (n >= 40) failures++;
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog: whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_of_test();
  end

  // ==============================================
  // test sequence
  initial begin
    mclk = 0;
    rst_n = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {usbOkIrqIn, buck1PgIn, buckPgIrqIn, otherRouteIrq} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdr(`IDX_PIN_SEVEN_CONFIG);
    `CHK(rd[4:0], 5'h00)
    `CHK({pinOe_n, pullUpEn, pullDownEn}, 3'b100)
    $display("test reset done");
    // each drive style and level, each input pull setting, and a pullup set while output
    for (int i = 0; i < 8; i++) begin
      cfg = cfgs[i];
      drv = cfg[2] & ~(cfg[3] & cfg[4]);
      wr(`IDX_PIN_SEVEN_CONFIG, cfg);
      `CHK(resp, `RESP_OKAY)
      repeat (4) @(posedge mclk);
      `CHK(pinOe_n, ~drv)
      if (drv) `CHK(pinOut, cfg[4])
      `CHK(pullUpEn, ~cfg[2] & cfg[1] & cfg[0])
      `CHK(pullDownEn, ~cfg[2] & cfg[1] & ~cfg[0])
      rdr(`IDX_PIN_SEVEN_CONFIG);
      `CHK(rd[4:0], cfg[4:0])
      if (drv) `CHK(rd[7], cfg[4])
      else if (~cfg[2] & cfg[1]) `CHK(rd[7], cfg[0])
    end
    $display("test pins done");
    // each status source alone, then all together
    for (int i = 0; i < 5; i++) begin
      pat = (i == 4) ? 4'hF : 4'h1 << i;
      usbOkIrqIn <= pat[3];
      buckPgIrqIn <= pat[2:0];
      repeat (2) @(posedge mclk);
      rdr(`IDX_PIN_IRQ_STATUS);
      `CHK(rd[7:0], {2'b00, pat[3], 2'b00, pat[2:0]})
    end
    // writes to the status register must not stick
    wr(`IDX_PIN_IRQ_STATUS, 8'h00);
    rdr(`IDX_PIN_IRQ_STATUS);
    `CHK(rd[7:0], 8'h27)
    $display("test status done");
    // rises latched, masked, unmasked, cleared, raised again
    rdr(`IDX_EVT_STATUS);
    `CHK(rd[4:0], 5'h1E)
    `CHK(irq, 1'b0)
    wr(`IDX_EVT_MASK, 8'h04);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    wr(`IDX_EVT_STATUS, 8'h04);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    rdr(`IDX_EVT_STATUS);
    `CHK(rd[4:0], 5'h1A)
    buckPgIrqIn[0] <= 1'b0;
    repeat (2) @(posedge mclk);
    buckPgIrqIn[0] <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b1)
    $display("test interrupt done");
    // route select readback, then one pin at a time
    wr(`IDX_BUCK1_ROUTE, 8'hFF);
    rdr(`IDX_BUCK1_ROUTE);
    `CHK(rd[7:0], 8'h78)
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_BUCK1_ROUTE, {1'b0, 4'h1 << i, 3'b000});
      repeat (2) @(posedge mclk);
      `CHK(routedPin, 4'h1 << i)
    end
    // buck1 on pin 0, other source on pin 3; both assert, then buck1 drops
    wr(`IDX_BUCK1_ROUTE, 8'h08);
    otherRouteIrq <= 4'h8;
    repeat (2) @(posedge mclk);
    `CHK(routedPin, 4'h9)
    buckPgIrqIn[0] <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(routedPin, 4'h8)
    // change flag set by a power-good change, gone after one read
    buck1PgIn <= 1'b1;
    repeat (2) @(posedge mclk);
    rdr(`IDX_BUCK1_ROUTE);
    `CHK(rd[7], 1'b1)
    rdr(`IDX_BUCK1_ROUTE);
    `CHK(rd[7], 1'b0)
    $display("test routing done");
    // unmapped place answers with an error and no data
    wr(8'h00, 8'h55);
    `CHK(resp, `RESP_SLVERR)
    rdr(8'h00);
    `CHK(resp, `RESP_SLVERR)
    `CHK(rd, 32'h0)
    $display("test unmapped done");
    end_of_test();
  end
endmodule
